// [rtl/eau_regs.vh]
// constants for the extended arithmetic unit: offsets, fields, reset values and timings
`ifndef EAU_REGS_VH
`define EAU_REGS_VH

// ----------------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define EAU_OFS_CMD 5'h00
`define EAU_OFS_OPA 5'h04
`define EAU_OFS_OPB 5'h08
`define EAU_OFS_RES 5'h0C
`define EAU_OFS_STAT 5'h10
`define EAU_OFS_FSP 5'h14
`define EAU_OFS_ADDR_HI 5'h18
`define EAU_OFS_ADDR_LO 5'h1C

// ----------------------------------------------------------------------------
// command fields and operation codes
// ----------------------------------------------------------------------------
`define EAU_CMD_OP_MSB 2
`define EAU_CMD_OP_LSB 0
`define EAU_CMD_ODD_BIT 3
`define EAU_OP_MUL 3'h0
`define EAU_OP_DIV 3'h1
`define EAU_OP_ASH 3'h2
`define EAU_OP_DOUBLE_WORD_SHIFT_INSTR 3'h3
`define EAU_OP_FLOAT_SUM_INSTR 3'h4
`define EAU_OP_FLOAT_DIFFERENCE_INSTR 3'h5
`define EAU_OP_FLOAT_PRODUCT_INSTR 3'h6
`define EAU_OP_FLOAT_QUOTIENT_INSTR 3'h7

// ----------------------------------------------------------------------------
// status fields
// ----------------------------------------------------------------------------
`define EAU_ST_BUSY 0
`define EAU_ST_C 1
`define EAU_ST_V 2
`define EAU_ST_Z 3
`define EAU_ST_N 4
`define EAU_ST_WR_R 5
`define EAU_ST_WR_R1 6
`define EAU_ST_TRAP 7
`define EAU_ST_ABORT 8

// ----------------------------------------------------------------------------
// reset values and floating layout
// ----------------------------------------------------------------------------
`define EAU_RST_WORD 32'h00000000
`define EAU_RST_FSP 16'h0000
`define EAU_EXP_BIAS 12'h080
`define EAU_FAC_HI_OFS 16'h0004
`define EAU_FAC_LO_OFS 16'h0006
`define EAU_SRC_HI_OFS 16'h0000
`define EAU_SRC_LO_OFS 16'h0002

// ----------------------------------------------------------------------------
// timing: figures in ns, cycle counts derived from the clock period
// ----------------------------------------------------------------------------
`define EAU_CLK_NS 10
`define EAU_MUL_NS 9500
`define EAU_DIV_NS 10500
`define EAU_ASH_NS 3400
`define EAU_DOUBLE_WORD_SHIFT_INSTR_NS 3800
`define EAU_SHIFT_STEP_NS 300
`define EAU_FLOAT_SUM_INSTR_NS 18780
`define EAU_FLOAT_DIFFERENCE_INSTR_NS 19080
`define EAU_FLOAT_PRODUCT_INSTR_NS 29000
`define EAU_FLOAT_QUOTIENT_INSTR_NS 46270
`define EAU_ABORT_NS 8000
`define EAU_MUL_CYC (`EAU_MUL_NS / `EAU_CLK_NS)
`define EAU_DIV_CYC (`EAU_DIV_NS / `EAU_CLK_NS)
`define EAU_ASH_CYC (`EAU_ASH_NS / `EAU_CLK_NS)
`define EAU_DOUBLE_WORD_SHIFT_INSTR_CYC (`EAU_DOUBLE_WORD_SHIFT_INSTR_NS / `EAU_CLK_NS)
`define EAU_SHIFT_STEP_CYC (`EAU_SHIFT_STEP_NS / `EAU_CLK_NS)
`define EAU_FLOAT_SUM_INSTR_CYC (`EAU_FLOAT_SUM_INSTR_NS / `EAU_CLK_NS)
`define EAU_FLOAT_DIFFERENCE_INSTR_CYC (`EAU_FLOAT_DIFFERENCE_INSTR_NS / `EAU_CLK_NS)
`define EAU_FLOAT_PRODUCT_INSTR_CYC (`EAU_FLOAT_PRODUCT_INSTR_NS / `EAU_CLK_NS)
`define EAU_FLOAT_QUOTIENT_INSTR_CYC (`EAU_FLOAT_QUOTIENT_INSTR_NS / `EAU_CLK_NS)
`define EAU_ABORT_CYC (`EAU_ABORT_NS / `EAU_CLK_NS)

`endif

// [rtl/eau_core.v]
// extended arithmetic unit: integer multiply, divide, shifts and single-precision floating ops
//
// The address map and the Avalon-MM interface to the registers were chosen for this implementation.
`default_nettype none
`include "eau_regs.vh"

module eau_core #(
    parameter FLOAT_QUOTIENT_INSTR_CYCLES = `EAU_FLOAT_QUOTIENT_INSTR_CYC
) (
    // clock and reset
    input wire core_clk,
    input wire rst_n,
    // host data path port
    input wire [4:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    // processor bus request level, asynchronous
    input wire bus_request_level,
    // instruction boundary and divide trap pulses
    output reg op_done,
    output reg div_trap
);

    // ------------------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------------------
    function [31:0] merge_be;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] be;
        integer k;
        begin
            merge_be = old;
            for (k = 0; k < 4; k = k + 1) begin
                if (be[k]) merge_be[k*8 +: 8] = nw[k*8 +: 8];
            end
        end
    endfunction

    // cycle counts stay far below 8192, so the upper integer bits are dropped on purpose
    function [12:0] cyc13;
        input integer n;
        begin
            cyc13 = n[12:0];
        end
    endfunction

    // returns {c, v, result}; short mode keeps the 16-bit operand in bits 31:16
    function [33:0] shift_fn;
        input [31:0] val;
        input [5:0] cnt;
        input short;
        reg [63:0] x;
        reg [63:0] y;
        reg [5:0] n;
        reg cy;
        begin
            x = {{31{val[31]}}, val, 1'b0};
            n = 6'h00 - cnt;
            if (cnt[5]) begin
                y = $signed(x) >>> n;
                cy = short ? y[16] : y[0];
            end else begin
                y = x << cnt;
                cy = y[33];
            end
            if (cnt == 6'h00) cy = 1'b0;
            shift_fn = {cy, ~((&y[63:32]) | ~(|y[63:32])), y[32:1]};
        end
    endfunction

    // returns {ovf, unf, word}; value is mag / 2^51 * 2^(e - 128)
    function [33:0] fp_norm;
        input [50:0] mag;
        input [11:0] e;
        input sgn;
        reg [50:0] m;
        reg [11:0] ex;
        reg [24:0] r;
        integer k;
        begin
            m = mag;
            ex = e;
            for (k = 0; k < 51; k = k + 1) begin
                if (!m[50] && m != 51'h0) begin
                    m = m << 1;
                    ex = ex - 12'h001;
                end
            end
            r = {1'b0, m[50:27]} + {24'h000000, |m[26:0]};
            if (r[24]) begin
                r = r >> 1;
                ex = ex + 12'h001;
            end
            if (mag == 51'h0) fp_norm = {2'b00, `EAU_RST_WORD};
            else if (!ex[11] && ex > 12'h0FF) fp_norm = {2'b10, `EAU_RST_WORD};
            else if (ex[11] || ex == 12'h000) fp_norm = {2'b01, `EAU_RST_WORD};
            else fp_norm = {2'b00, sgn, ex[7:0], r[22:0]};
        end
    endfunction

    function [23:0] fp_mant;
        input [31:0] w;
        begin
            fp_mant = (w[30:23] == 8'h00) ? 24'h000000 : {1'b1, w[22:0]};
        end
    endfunction

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    localparam ST_IDLE = 1'b0;
    localparam ST_RUN = 1'b1;

    reg state;
    reg [31:0] cmd;
    reg [31:0] opa;
    reg [31:0] opb;
    reg [31:0] res;
    reg [15:0] float_stack_pointer;
    reg [3:0] nzvc;
    reg wr_r;
    reg wr_r1;
    reg trap;
    reg aborted;
    reg [12:0] cnt;
    reg is_float;
    reg [31:0] pend_res;
    reg [3:0] pend_nzvc;
    reg pend_wr_r;
    reg pend_wr_r1;
    reg pend_trap;
    reg breq_meta;
    reg breq;

    wire accept = (avs_read | avs_write) & ~avs_waitrequest;
    wire wr_acc = accept & avs_write;
    wire start = wr_acc && avs_address == `EAU_OFS_CMD && state == ST_IDLE;
    wire [2:0] op_sel = avs_writedata[`EAU_CMD_OP_MSB:`EAU_CMD_OP_LSB];
    wire odd_reg = avs_writedata[`EAU_CMD_ODD_BIT];
    wire [31:0] fsp_new = merge_be({16'h0000, float_stack_pointer}, avs_writedata, avs_byteenable);

    // ------------------------------------------------------------------------
    // operation datapath, evaluated on the start cycle
    // ------------------------------------------------------------------------
    reg [31:0] c_res;
    reg [3:0] c_nzvc;
    reg c_wr_r;
    reg c_wr_r1;
    reg c_trap;
    reg [12:0] c_cyc;
    reg signed [31:0] prod;
    reg signed [32:0] quo;
    reg signed [32:0] rem;
    reg [33:0] sh;
    reg [5:0] amag;
    reg [3:0] rot;
    reg [15:0] rw;
    reg [33:0] fr;
    reg [23:0] ma;
    reg [23:0] mb;
    reg [50:0] xbig;
    reg [50:0] xsml;
    reg [50:0] xs;
    reg [50:0] fmag;
    reg [73:0] fq;
    reg [47:0] fprod;
    reg [11:0] fe;
    reg fs;
    reg sbig;
    reg ssml;
    reg [7:0] dexp;
    reg [31:0] fac;

    always @* begin
        c_res = opa;
        c_nzvc = 4'h0;
        c_wr_r = 1'b0;
        c_wr_r1 = 1'b0;
        c_trap = 1'b0;
        c_cyc = 13'h0001;
        prod = $signed(opa[15:0]) * $signed(opb[15:0]);
        quo = 33'h0;
        rem = 33'h0;
        sh = 34'h0;
        amag = opb[5] ? (6'h00 - opb[5:0]) : opb[5:0];
        rot = opb[5] ? (4'h0 - amag[3:0]) : amag[3:0];
        rw = 16'h0000;
        fr = 34'h0;
        ma = fp_mant(opa);
        mb = fp_mant(opb);
        // sized target keeps all 48 product bits; a concatenation would cut it to 24
        fprod = ma * mb;
        xbig = 51'h0;
        xsml = 51'h0;
        xs = 51'h0;
        fmag = 51'h0;
        fq = 74'h0;
        fe = 12'h000;
        fs = 1'b0;
        sbig = 1'b0;
        ssml = 1'b0;
        dexp = 8'h00;
        fac = opa;
        case (op_sel)
            `EAU_OP_MUL: begin
                c_cyc = cyc13(`EAU_MUL_CYC);
                c_nzvc = {prod[31], prod == 32'h0, 1'b0,
                          prod[31:15] != 17'h0 && prod[31:15] != 17'h1FFFF};
                c_wr_r = 1'b1;
                c_wr_r1 = ~odd_reg;
                c_res = odd_reg ? {prod[15:0], 16'h0000} : prod;
            end
            `EAU_OP_DIV: begin
                c_cyc = cyc13(`EAU_DIV_CYC);
                if (opb[15:0] == 16'h0000) begin
                    c_nzvc = 4'b0011;
                    c_trap = 1'b1;
                end else begin
                    quo = $signed({opa[31], opa}) / $signed({{17{opb[15]}}, opb[15:0]});
                    rem = $signed({opa[31], opa}) % $signed({{17{opb[15]}}, opb[15:0]});
                    if (quo[32:15] != 18'h0 && quo[32:15] != 18'h3FFFF) begin
                        c_nzvc = 4'b0010;
                        c_trap = 1'b1;
                    end else begin
                        c_nzvc = {quo[15], quo[15:0] == 16'h0000, 2'b00};
                        c_res = {quo[15:0], rem[15:0]};
                        c_wr_r = 1'b1;
                        c_wr_r1 = 1'b1;
                    end
                end
            end
            `EAU_OP_ASH: begin
                c_cyc = cyc13(`EAU_ASH_CYC + amag * `EAU_SHIFT_STEP_CYC);
                sh = shift_fn({opa[15:0], 16'h0000}, opb[5:0], 1'b1);
                c_res = {sh[31:16], 16'h0000};
                c_nzvc = {sh[31], sh[31:16] == 16'h0000, sh[32], sh[33]};
                c_wr_r = 1'b1;
            end
            `EAU_OP_DOUBLE_WORD_SHIFT_INSTR: begin
                c_cyc = cyc13(`EAU_DOUBLE_WORD_SHIFT_INSTR_CYC + amag * `EAU_SHIFT_STEP_CYC);
                if (odd_reg) begin
                    // a rotate cannot overflow the word, so V only flags a sign change
                    rw = (opa[15:0] << rot) | (opa[15:0] >> (5'h10 - rot));
                    c_res = {rw, 16'h0000};
                    c_nzvc = {rw[15], rw == 16'h0000, rw[15] ^ opa[15],
                              opb[5:0] != 6'h00 && (opb[5] ? rw[15] : rw[0])};
                    c_wr_r = 1'b1;
                end else begin
                    sh = shift_fn(opa, opb[5:0], 1'b0);
                    c_res = sh[31:0];
                    c_nzvc = {sh[31], sh[31:0] == 32'h0, sh[32], sh[33]};
                    c_wr_r = 1'b1;
                    c_wr_r1 = 1'b1;
                end
            end
            default: begin
                case (op_sel)
                    `EAU_OP_FLOAT_SUM_INSTR: c_cyc = cyc13(`EAU_FLOAT_SUM_INSTR_CYC);
                    `EAU_OP_FLOAT_DIFFERENCE_INSTR: c_cyc = cyc13(`EAU_FLOAT_DIFFERENCE_INSTR_CYC);
                    `EAU_OP_FLOAT_PRODUCT_INSTR: c_cyc = cyc13(`EAU_FLOAT_PRODUCT_INSTR_CYC);
                    default: c_cyc = cyc13(FLOAT_QUOTIENT_INSTR_CYCLES);
                endcase
                if (op_sel == `EAU_OP_FLOAT_SUM_INSTR || op_sel == `EAU_OP_FLOAT_DIFFERENCE_INSTR) begin
                    ssml = opb[31] ^ (op_sel == `EAU_OP_FLOAT_DIFFERENCE_INSTR);
                    if (opa[30:23] >= opb[30:23]) begin
                        xbig = {1'b0, ma, 26'h0};
                        xsml = {1'b0, mb, 26'h0};
                        sbig = opa[31];
                        dexp = opa[30:23] - opb[30:23];
                        fe = {4'h0, opa[30:23]} + 12'h001;
                    end else begin
                        xbig = {1'b0, mb, 26'h0};
                        xsml = {1'b0, ma, 26'h0};
                        sbig = ssml;
                        ssml = opa[31];
                        dexp = opb[30:23] - opa[30:23];
                        fe = {4'h0, opb[30:23]} + 12'h001;
                    end
                    // bits shifted out collapse into a sticky bit for rounding
                    xs = xsml >> dexp;
                    xs[0] = xs[0] | ((xs << dexp) != xsml);
                    if (sbig == ssml) begin
                        fmag = xbig + xs;
                        fs = sbig;
                    end else if (xbig >= xs) begin
                        fmag = xbig - xs;
                        fs = sbig;
                    end else begin
                        fmag = xs - xbig;
                        fs = ssml;
                    end
                end else if (op_sel == `EAU_OP_FLOAT_PRODUCT_INSTR) begin
                    fmag = {fprod, 3'h0};
                    fe = {4'h0, opa[30:23]} + {4'h0, opb[30:23]} - `EAU_EXP_BIAS;
                    fs = opa[31] ^ opb[31];
                end else if (mb != 24'h000000) begin
                    fq = {ma, 50'h0} / {50'h0, mb};
                    fmag = fq[50:0];
                    fmag[0] = fmag[0] | (fq * {50'h0, mb} != {ma, 50'h0});
                    fe = {4'h0, opa[30:23]} - {4'h0, opb[30:23]} + `EAU_EXP_BIAS + 12'h001;
                    fs = opa[31] ^ opb[31];
                end
                fr = fp_norm(fmag, fe, fs);
                if (op_sel == `EAU_OP_FLOAT_QUOTIENT_INSTR && mb == 24'h000000) begin
                    c_nzvc = {opa[31], opa == 32'h0, 2'b01};
                end else begin
                    if (fr[33:32] == 2'b00) begin
                        fac = fr[31:0];
                        c_wr_r = 1'b1;
                        c_wr_r1 = 1'b1;
                    end
                    c_nzvc = {fac[31] | fr[32], fac == 32'h0, |fr[33:32], 1'b0};
                end
                c_res = fac;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // bus request synchroniser
    // ------------------------------------------------------------------------
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            breq_meta <= 1'b0;
            breq <= 1'b0;
        end else begin
            breq_meta <= bus_request_level;
            breq <= breq_meta;
        end
    end

    // ------------------------------------------------------------------------
    // bus slave: one wait state, then the answer
    // ------------------------------------------------------------------------
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= `EAU_RST_WORD;
            opa <= `EAU_RST_WORD;
            opb <= `EAU_RST_WORD;
            float_stack_pointer <= `EAU_RST_FSP;
        end else begin
            if ((avs_read | avs_write) && avs_waitrequest) begin
                avs_waitrequest <= 1'b0;
                // writes leave the last read word standing
                if (avs_read) begin
                    if (avs_address == `EAU_OFS_CMD) avs_readdata <= cmd;
                    else if (avs_address == `EAU_OFS_OPA) avs_readdata <= opa;
                    else if (avs_address == `EAU_OFS_OPB) avs_readdata <= opb;
                    else if (avs_address == `EAU_OFS_RES) avs_readdata <= res;
                    else if (avs_address == `EAU_OFS_STAT)
                        avs_readdata <= {23'h0, aborted, trap, wr_r1, wr_r, nzvc, state};
                    else if (avs_address == `EAU_OFS_FSP) avs_readdata <= {16'h0000, float_stack_pointer};
                    else if (avs_address == `EAU_OFS_ADDR_HI)
                        avs_readdata <= {float_stack_pointer + `EAU_FAC_HI_OFS, float_stack_pointer + `EAU_SRC_HI_OFS};
                    else if (avs_address == `EAU_OFS_ADDR_LO)
                        avs_readdata <= {float_stack_pointer + `EAU_FAC_LO_OFS, float_stack_pointer + `EAU_SRC_LO_OFS};
                    else avs_readdata <= `EAU_RST_WORD;
                end
            end else begin
                avs_waitrequest <= 1'b1;
            end
            // operands are frozen while an operation runs
            if (wr_acc && state == ST_IDLE) begin
                if (avs_address == `EAU_OFS_OPA) opa <= merge_be(opa, avs_writedata, avs_byteenable);
                else if (avs_address == `EAU_OFS_OPB)
                    opb <= merge_be(opb, avs_writedata, avs_byteenable);
                else if (avs_address == `EAU_OFS_FSP)
                    float_stack_pointer <= fsp_new[15:0];
            end
        end
    end

    // ------------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------------
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            cmd <= `EAU_RST_WORD;
            res <= `EAU_RST_WORD;
            nzvc <= 4'h0;
            wr_r <= 1'b0;
            wr_r1 <= 1'b0;
            trap <= 1'b0;
            aborted <= 1'b0;
            cnt <= 13'h0000;
            is_float <= 1'b0;
            pend_res <= `EAU_RST_WORD;
            pend_nzvc <= 4'h0;
            pend_wr_r <= 1'b0;
            pend_wr_r1 <= 1'b0;
            pend_trap <= 1'b0;
            op_done <= 1'b0;
            div_trap <= 1'b0;
        end else begin
            op_done <= 1'b0;
            div_trap <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (start) begin
                        state <= ST_RUN;
                        cmd <= {28'h0, odd_reg, op_sel};
                        cnt <= c_cyc;
                        is_float <= op_sel[2];
                        pend_res <= c_res;
                        pend_nzvc <= c_nzvc;
                        pend_wr_r <= c_wr_r;
                        pend_wr_r1 <= c_wr_r1;
                        pend_trap <= c_trap;
                        aborted <= 1'b0;
                        wr_r <= 1'b0;
                        wr_r1 <= 1'b0;
                        trap <= 1'b0;
                    end
                end
                default: begin
                    // results appear only at the end, so interrupts see a clean boundary
                    if (is_float && breq && cnt > `EAU_ABORT_CYC) begin
                        state <= ST_IDLE;
                        aborted <= 1'b1;
                        op_done <= 1'b1;
                    end else if (cnt <= 13'h0001) begin
                        state <= ST_IDLE;
                        res <= pend_res;
                        nzvc <= pend_nzvc;
                        wr_r <= pend_wr_r;
                        wr_r1 <= pend_wr_r1;
                        trap <= pend_trap;
                        div_trap <= pend_trap;
                        op_done <= 1'b1;
                    end else begin
                        cnt <= cnt - 13'h0001;
                    end
                end
            endcase
        end
    end

endmodule // eau_core
`default_nettype wire

// [verification/eau_host.sv]
// host side stand-in: raises the processor bus request on demand
`default_nettype none
module eau_host (
    // clock and control from the bench
    input wire logic core_clk,
    input wire logic req_go,
    // request toward the unit
    output logic bus_request_level
);
    timeunit 1ns;
    timeprecision 1ns;
    // registered so the request moves only on the unit's sampling edge, the rising edge of core_clk
    always @(posedge core_clk) bus_request_level <= req_go;
endmodule // eau_host
`default_nettype wire

// [verification/eau_core_sva.sv]
// concurrent checks on the unit's host port
`default_nettype none
module eau_core_sva (
    // clock, reset and bus
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // operation events
    input wire logic op_done,
    input wire logic div_trap
);
    timeunit 1ns;
    timeprecision 1ns;
    logic cmd_wait;
    logic [11:0] cmd_age;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    chk_ack_next: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("no ack");
    chk_ack_single: assert property (
        !avs_waitrequest |=> avs_waitrequest) else $error("long ack");
    chk_idle_wait: assert property (
        !avs_read && !avs_write |=> avs_waitrequest) else $error("stray ack");
    chk_rdata_cause: assert property (
        $changed(avs_readdata) |-> $past(avs_read && avs_waitrequest)) else $error("rdata");
    chk_done_pulse: assert property (
        op_done |=> !op_done) else $error("done width");
    chk_trap_done: assert property (
        div_trap |-> op_done) else $error("trap alone");
    chk_cmd_quiet: assert property (
        avs_write && !avs_waitrequest && avs_address == 5'h00 |=> !op_done [*8])
        else $error("early done");
    // the longest operation is far beyond a delay range, so its age is counted here
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_wait <= 1'b0;
            cmd_age <= 12'h000;
        end else if (avs_write && !avs_waitrequest && avs_address == 5'h00) begin
            cmd_wait <= 1'b1;
            cmd_age <= 12'h000;
        end else if (op_done) begin
            cmd_wait <= 1'b0;
        end else if (cmd_wait && cmd_age != 12'hFFF) begin
            cmd_age <= cmd_age + 12'h001;
        end
    end
    chk_cmd_bound: assert property (
        !cmd_wait || cmd_age < 12'hBB8)
        else $error("no done");
endmodule // eau_core_sva
bind eau_core eau_core_sva u_eau_core_sva (.core_clk, .rst_n, .avs_address, .avs_read,
    .avs_write, .avs_readdata, .avs_waitrequest, .op_done, .div_trap);
`default_nettype wire

// [verification/eau_core_tb.sv]
// self-checking bench for the extended arithmetic unit
`default_nettype none
module eau_core_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic req_go = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, rd, st;
    logic avs_waitrequest, op_done, div_trap, bus_request_level, trapped;
    int miscompares = 0;
    int comparisons = 0;
    int cyc, n1;
    // short divide time keeps the run brief
    eau_core #(.FLOAT_QUOTIENT_INSTR_CYCLES(20)) u_eau_core (.core_clk(core_clk), .rst_n(rst_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .bus_request_level(bus_request_level),
        .op_done(op_done), .div_trap(div_trap));
    eau_host u_eau_host (.core_clk(core_clk), .req_go(req_go),
        .bus_request_level(bus_request_level));
    initial forever #5 core_clk = ~core_clk;
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0 && ++n < 50);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50) miscompares++;
    endtask
    task automatic run(input logic [3:0] op, input logic [31:0] a, b, input logic brk);
        bus(1'b1, 5'h04, a);
        bus(1'b1, 5'h08, b);
        bus(1'b1, 5'h00, {28'h0, op});
        cyc = 0;
        trapped = 1'b0;
        // a late request still leaves far more than the abort margin
        if (brk) repeat (20) @(posedge core_clk);
        req_go <= brk;
        while (op_done !== 1'b1 && cyc < 4000) begin
            @(posedge core_clk);
            cyc++;
            trapped |= div_trap === 1'b1;
        end
        req_go <= 1'b0;
        if (cyc >= 4000) miscompares++;
        bus(1'b0, 5'h10, 32'h0);
        st = rd;
        bus(1'b0, 5'h0C, 32'h0);
        $display("op %h done in %0d", op, cyc);
    endtask
    task automatic test_done;
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        run(4'h0, 32'h0000FFFD, 32'h7, 1'b0);
        cmp(rd, 32'hFFFFFFEB);
        cmp(st, 32'h70);
        run(4'h8, 32'h100, 32'h100, 1'b0);
        cmp(st, 32'h22);
        cmp(rd[31:16], 32'h0);
        run(4'h1, 32'hFFFFFFF9, 32'h2, 1'b0);
        cmp(rd, 32'hFFFDFFFF);
        run(4'h1, 32'h1, 32'h0, 1'b0);
        cmp({st[30:0], trapped}, 32'h10D);
        run(4'h1, 32'h10000, 32'h1, 1'b0);
        cmp({st[30:0], trapped}, 32'h109);
        run(4'h2, 32'h1, 32'hF, 1'b0);
        cmp(rd[31:16], 32'h8000);
        n1 = cyc;
        run(4'h2, 32'h1, 32'h0, 1'b0);
        cmp(rd[31:16], 32'h1);
        cmp(n1 - cyc, 32'h1C2);
        run(4'h2, 32'h8000, 32'h20, 1'b0);
        cmp(rd[31:16], 32'hFFFF);
        run(4'h3, 32'h8000, 32'h1, 1'b0);
        cmp(rd, 32'h10000);
        run(4'h3, 32'h10000, 32'h3F, 1'b0);
        cmp(rd, 32'h8000);
        run(4'hB, 32'h8001, 32'h1, 1'b0);
        cmp(rd[31:16], 32'h3);
        run(4'h4, 32'h40800000, 32'h40800000, 1'b0);
        cmp(rd, 32'h41000000);
        run(4'h4, 32'h40800000, 32'h34000000, 1'b0);
        cmp(rd, 32'h40800001);
        run(4'h5, 32'h40800000, 32'h40800000, 1'b0);
        cmp({rd[31:4], st[3:0]}, 32'h8);
        run(4'h6, 32'h41000000, 32'h41000000, 1'b0);
        cmp(rd, 32'h41800000);
        run(4'h7, 32'h41000000, 32'h40800000, 1'b0);
        cmp(rd, 32'h41000000);
        run(4'h7, 32'h41000000, 32'h0, 1'b0);
        cmp(st, 32'h2);
        run(4'h6, 32'h7F800000, 32'h7F800000, 1'b0);
        cmp(st, 32'h4);
        run(4'h6, 32'h41000000, 32'h41000000, 1'b1);
        cmp(st[8], 32'h1);
        bus(1'b1, 5'h14, 32'h100);
        bus(1'b0, 5'h18, 32'h0);
        cmp(rd, 32'h01040100);
        bus(1'b0, 5'h1C, 32'h0);
        cmp(rd, 32'h01060102);
        bus(1'b0, 5'h1E, 32'h0);
        cmp(rd, 32'h0);
        $display("register map test done");
        test_done();
    end
    initial begin
        #600000;
        miscompares++;
        test_done();
    end
endmodule // eau_core_tb
`default_nettype wire
